/* File: inc/fwsr_pkg.sv */
/*
 Constants for the flash status polling controller: APB register map, field positions,
 flash status bit positions and timing counts.
 Assumes a 40 MHz pclk and a 16-bit parallel NOR flash with active-low strobes.
*/
package fwsr_pkg;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ADDR = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_RDAT = 8'h10;
   // Control register fields (write one to start)
   localparam int CTRL_GO = 0;
   localparam int CTRL_CMD_LSB = 1;
   localparam int CTRL_CMD_W = 3;
   // Commands
   localparam logic [2:0] CMD_WRITE = 3'h0;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_POLL = 3'h2;
   localparam logic [2:0] CMD_RESET = 3'h3;
   localparam logic [2:0] CMD_ABORT_RESET = 3'h4;
   localparam logic [2:0] CMD_ERASE_CHECK = 3'h5;
   // Status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_ABORT = 3;
   localparam int ST_ERASE_STARTED = 4;
   localparam int ST_SUSPENDED = 5;
   localparam int ST_RB = 6;
   // Flash status bit positions
   localparam int DQ_BUF_ABORT = 1;
   localparam int DQ_TOGGLE_TWO = 2;
   localparam int DQ_ERASE_TO = 3;
   localparam int DQ_LIMIT = 5;
   localparam int DQ_TOGGLE_ONE = 6;
   localparam int DQ_POLL = 7;
   // Command words and unlock addresses
   localparam logic [15:0] WD_AA = 16'h00aa;
   localparam logic [15:0] WD_55 = 16'h0055;
   localparam logic [15:0] WD_F0 = 16'h00f0;
   localparam logic [15:0] WD_F0_ABORT = 16'h00f0;
   localparam logic [23:0] WA_555 = 24'h000555;
   localparam logic [23:0] WA_2AA = 24'h0002aa;
   // Bus timing in ns and derived cycles at 40 MHz
   localparam int CLK_NS = 25;
   localparam int STROBE_NS = 70;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_NS = 30;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
endpackage

/* File: verilog/fwsr_host.sv */
/*
 Host controller that polls a parallel NOR flash for embedded operation status.
 Software drives it over APB; the flash pins are driven from flip-flops.
 Assumes flash inputs are synchronous to pclk and the flash answers within the strobe time.
*/
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fwsr_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [23:0] flash_addr,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [15:0] flash_dq_in,
   input wire logic ready_busy_n
);
   typedef enum logic [6:0] {
      S_IDLE = 7'b0000001,
      S_WR = 7'b0000010,
      S_RD = 7'b0000100,
      S_GAP = 7'b0001000,
      S_EVAL = 7'b0010000,
      S_SEQ = 7'b0100000,
      S_END = 7'b1000000
   } fwsr_state_e;

   fwsr_state_e state_reg, state_next;
   logic [23:0] addr_reg;
   logic [15:0] data_reg;
   logic [2:0] cmd_reg;
   logic [31:0] stat_reg;
   logic [15:0] rdat_reg;
   logic [15:0] prev_reg;
   logic [1:0] nread_reg;
   logic recheck_reg;
   logic [1:0] seq_reg;
   logic [fwsr_pkg::CNT_W-1:0] cnt_reg;
   logic [23:0] flash_addr_reg;
   logic ce_n_reg, oe_n_reg, we_n_reg, dq_oe_n_reg;
   logic [15:0] dq_out_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg, pready_reg;

   // Bus decode
   wire logic wr_en = psel & penable & pwrite;
   wire logic rd_en = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = paddr == fwsr_pkg::ADDR_CTRL;
   wire logic hit_addr = paddr == fwsr_pkg::ADDR_ADDR;
   wire logic hit_data = paddr == fwsr_pkg::ADDR_DATA;
   wire logic hit_stat = paddr == fwsr_pkg::ADDR_STAT;
   wire logic hit_rdat = paddr == fwsr_pkg::ADDR_RDAT;
   wire logic mapped = hit_ctrl | hit_addr | hit_data | hit_stat | hit_rdat;
   wire logic go = wr_en & hit_ctrl & pwdata[fwsr_pkg::CTRL_GO] & (state_reg == S_IDLE);
   wire logic [2:0] go_cmd = pwdata[fwsr_pkg::CTRL_CMD_LSB +: fwsr_pkg::CTRL_CMD_W];
   wire logic strobe_end = cnt_reg == fwsr_pkg::CNT_W'(fwsr_pkg::STROBE_CYC - 1);
   wire logic gap_end = cnt_reg == fwsr_pkg::CNT_W'(fwsr_pkg::GAP_CYC - 1);
   wire logic [15:0] sample = flash_dq_in;

   // Toggle comparison on the two latest status reads
   wire logic t1_moving = sample[fwsr_pkg::DQ_TOGGLE_ONE] ^ prev_reg[fwsr_pkg::DQ_TOGGLE_ONE];
   wire logic t2_moving = sample[fwsr_pkg::DQ_TOGGLE_TWO] ^ prev_reg[fwsr_pkg::DQ_TOGGLE_TWO];
   wire logic limit_hi = sample[fwsr_pkg::DQ_LIMIT];
   // Abort only counts on two toggling status reads, so array data with bit one set is harmless
   wire logic abort_hi = sample[fwsr_pkg::DQ_BUF_ABORT] & prev_reg[fwsr_pkg::DQ_BUF_ABORT]
                         & t1_moving;

   // Decide next step after the second status read
   function automatic logic [1:0] poll_verdict(input logic moving, input logic lim,
                                               input logic rechk);
      // 0 keep polling, 1 done, 2 failed, 3 recheck
      if (!moving) begin
         poll_verdict = 2'd1;
      end else if (rechk) begin
         poll_verdict = 2'd2;
      end else if (lim) begin
         poll_verdict = 2'd3;
      end else begin
         poll_verdict = 2'd0;
      end
   endfunction

   wire logic [1:0] verdict = poll_verdict(t1_moving, limit_hi, recheck_reg);

   // Word and address for each cycle of a reset sequence
   wire logic [1:0] seq_len = (cmd_reg == fwsr_pkg::CMD_ABORT_RESET) ? 2'd3 : 2'd1;
   // Command and step of the write being launched; the start cycle still holds the old command
   wire logic [2:0] wr_cmd = go ? go_cmd : cmd_reg;
   wire logic [1:0] wr_step = go ? 2'd0 : seq_reg + 2'd1;
   wire logic wr_seq = (wr_cmd == fwsr_pkg::CMD_RESET) | (wr_cmd == fwsr_pkg::CMD_ABORT_RESET);
   wire logic [15:0] seq_word = (wr_cmd != fwsr_pkg::CMD_ABORT_RESET) ? fwsr_pkg::WD_F0 :
                                (wr_step == 2'd0) ? fwsr_pkg::WD_AA :
                                (wr_step == 2'd1) ? fwsr_pkg::WD_55 : fwsr_pkg::WD_F0_ABORT;
   wire logic [23:0] seq_addr = (wr_step == 2'd1) ? fwsr_pkg::WA_2AA : fwsr_pkg::WA_555;
   // Pins load once on entry to an access, so address and data stand through the strobe
   wire logic wr_enter = (state_next == S_WR) & (state_reg != S_WR);
   wire logic rd_enter = (state_next == S_RD) & (state_reg != S_RD);
   wire logic is_seq = (cmd_reg == fwsr_pkg::CMD_RESET) | (cmd_reg == fwsr_pkg::CMD_ABORT_RESET);
   wire logic is_write = (cmd_reg == fwsr_pkg::CMD_WRITE) | is_seq;

   // Next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (go) begin
               state_next = ((go_cmd == fwsr_pkg::CMD_WRITE) | (go_cmd == fwsr_pkg::CMD_RESET)
                             | (go_cmd == fwsr_pkg::CMD_ABORT_RESET)) ? S_WR : S_RD;
            end
         end
         S_WR: if (strobe_end) state_next = S_GAP;
         S_RD: if (strobe_end) state_next = S_GAP;
         S_GAP: if (gap_end) state_next = is_write ? S_SEQ : S_EVAL;
         S_SEQ: state_next = (is_seq && seq_reg != seq_len - 2'd1) ? S_WR : S_END;
         S_EVAL: begin
            if (cmd_reg == fwsr_pkg::CMD_READ) begin
               state_next = S_END;
            end else if (nread_reg == 2'd0) begin
               state_next = S_RD; // A verdict needs two reads in a row
            end else if (cmd_reg == fwsr_pkg::CMD_ERASE_CHECK) begin
               state_next = S_END;
            end else begin
               state_next = (verdict == 2'd1 || verdict == 2'd2 || abort_hi) ? S_END : S_RD;
            end
         end
         S_END: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   // Sequencer state and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
      end
   end

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= '0;
         data_reg <= '0;
         cmd_reg <= fwsr_pkg::CMD_READ;
      end else begin
         if (wr_en && hit_addr && state_reg == S_IDLE) addr_reg <= pwdata[23:0];
         if (wr_en && hit_data && state_reg == S_IDLE) data_reg <= pwdata[15:0];
         if (go) cmd_reg <= go_cmd;
      end
   end

   // Poll bookkeeping: read count, previous sample, recheck flag, sequence step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '0;
         rdat_reg <= '0;
         nread_reg <= '0;
         recheck_reg <= 1'b0;
         seq_reg <= '0;
      end else if (go) begin
         nread_reg <= '0; // Each poll starts over from two fresh reads
         recheck_reg <= 1'b0;
         seq_reg <= '0;
      end else begin
         if (state_reg == S_SEQ) seq_reg <= seq_reg + 2'd1;
         if (state_reg == S_EVAL) begin
            prev_reg <= sample;
            rdat_reg <= sample;
            if (nread_reg != 2'd2) nread_reg <= nread_reg + 2'd1;
            if (cmd_reg == fwsr_pkg::CMD_POLL && nread_reg != 2'd0 && verdict == 2'd3) begin
               recheck_reg <= 1'b1; // Limit seen while toggling: one more compare
            end
         end
      end
   end

   // Status register; done and error bits are sticky until the next start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= '0;
      end else begin
         stat_reg[fwsr_pkg::ST_BUSY] <= state_next != S_IDLE;
         stat_reg[fwsr_pkg::ST_RB] <= ready_busy_n;
         if (go) begin
            stat_reg[5:1] <= '0;
         end else if (state_reg == S_EVAL && nread_reg != 2'd0) begin
            if (cmd_reg == fwsr_pkg::CMD_POLL) begin
               if (verdict == 2'd1) stat_reg[fwsr_pkg::ST_DONE] <= 1'b1;
               if (verdict == 2'd2) stat_reg[fwsr_pkg::ST_FAIL] <= 1'b1; // Reset next
               if (abort_hi) stat_reg[fwsr_pkg::ST_ABORT] <= 1'b1; // Abort reset next
               // Steady toggle one with toggle two moving: sector suspended
               if (!t1_moving && t2_moving) stat_reg[fwsr_pkg::ST_SUSPENDED] <= 1'b1;
            end
            if (cmd_reg == fwsr_pkg::CMD_ERASE_CHECK) begin
               // Optional when software keeps erase gaps short
               stat_reg[fwsr_pkg::ST_ERASE_STARTED] <= sample[fwsr_pkg::DQ_ERASE_TO];
               stat_reg[fwsr_pkg::ST_DONE] <= 1'b1;
            end
         end else if (state_reg == S_END && cmd_reg != fwsr_pkg::CMD_POLL
                      && cmd_reg != fwsr_pkg::CMD_ERASE_CHECK) begin
            stat_reg[fwsr_pkg::ST_DONE] <= 1'b1;
         end
      end
   end

   // Flash pin drive; every read is a fresh chip and output enable strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_addr_reg <= '0;
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         dq_oe_n_reg <= 1'b1;
         dq_out_reg <= '0;
      end else begin
         ce_n_reg <= ~((state_next == S_WR) | (state_next == S_RD));
         oe_n_reg <= ~(state_next == S_RD);
         we_n_reg <= ~(state_next == S_WR);
         dq_oe_n_reg <= ~(state_next == S_WR);
         if (wr_enter) begin
            flash_addr_reg <= wr_seq ? seq_addr : addr_reg;
            dq_out_reg <= wr_seq ? seq_word : data_reg;
         end else if (rd_enter) begin
            flash_addr_reg <= addr_reg;
         end
      end
   end

   // APB read data, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (rd_en) begin
         prdata_reg <= hit_ctrl ? {28'h0000000, cmd_reg, 1'b0} :
                       hit_addr ? {8'h00, addr_reg} :
                       hit_data ? {16'h0000, data_reg} :
                       hit_stat ? stat_reg :
                       hit_rdat ? {16'h0000, rdat_reg} : 32'h00000000;
      end
   end

   // Zero wait answer; error flag loaded in the setup cycle so it stands in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= 1'b1;
         pslverr_reg <= psel & ~penable & ~mapped;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign flash_addr = flash_addr_reg;
   assign flash_ce_n = ce_n_reg;
   assign flash_oe_n = oe_n_reg;
   assign flash_we_n = we_n_reg;
   assign flash_dq_out = dq_out_reg;
   assign flash_dq_oe_n = dq_oe_n_reg;
endmodule

/* File: verification/fwsr_host_sva.sv */
/*
 Checker for the flash status polling host: APB answers and flash strobe shape.
 Assumes one pclk domain and is bound to every fwsr_host instance.
*/
`timescale 1ns/1ps
module fwsr_host_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [23:0] flash_addr,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic flash_dq_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // One flash access: three strobe cycles, then two quiet cycles
   sequence s_access;
      !flash_ce_n [*3] ##1 flash_ce_n [*2];
   endsequence
   // Bus answers and flash pin discipline
   chk_zero_wait: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   chk_bad_addr: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
      else $error("unmapped address not refused");
   chk_strobe_shape: assert property ($fell(flash_ce_n) |-> s_access)
      else $error("flash access has wrong length");
   chk_read_fresh: assert property ($fell(flash_oe_n) |-> $fell(flash_ce_n) && flash_we_n)
      else $error("read not a fresh access");
   chk_write_drive: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n && flash_oe_n)
      else $error("write strobe without data drive");
   chk_read_float: assert property (!flash_oe_n |-> flash_dq_oe_n)
      else $error("data driven during read");
   chk_addr_hold: assert property (!flash_ce_n ##1 !flash_ce_n |-> $stable(flash_addr))
      else $error("address moved during access");
   chk_oe_gap: assert property ($rose(flash_oe_n) |-> flash_oe_n [*2])
      else $error("output enable gap too short");
endmodule

bind fwsr_host fwsr_host_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_dq_oe_n(flash_dq_oe_n));

/* File: verification/fwsr_flash_model.sv */
/*
 Behavioural flash answering status reads during embedded operations.
 Assumes the host strobes come from flops; faults are set by the bench.
*/
`timescale 1ns/1ps
module fwsr_flash_model (
   input wire logic [23:0] flash_addr,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [15:0] flash_dq_out,
   input wire logic fault_mode,
   input wire logic abort_mode,
   input wire logic [3:0] op_len,
   output logic [15:0] flash_dq_in,
   output logic ready_busy_n
);
   logic t1 = 1'b0, t2 = 1'b0, lim = 1'b0, eto = 1'b0, abt = 1'b0, ers = 1'b0, arm = 1'b0;
   logic [15:0] pd = 16'h0000, w1 = 16'h0000, w2 = 16'h0000;
   logic susp = 1'b0;
   logic [7:0] esec = 8'h00;
   logic [3:0] left = 4'h0;
   logic sel;
   initial flash_dq_in = 16'h0000;
   assign ready_busy_n = susp || !(left != 4'h0 || lim || abt);
   assign sel = ers && esec == flash_addr[23:16];
   // Command words taken on the closing write strobe
   always @(posedge flash_we_n) begin
      if (flash_dq_out == 16'h00f0) begin
         if (w1 == 16'h0055 && w2 == 16'h00aa) begin
            abt <= 1'b0;
            lim <= 1'b0;
            left <= 4'h0;
         end else if (!abt) begin
            lim <= 1'b0;
            left <= 4'h0;
         end
      end else if (arm) begin
         pd <= flash_dq_out;
         left <= op_len; // Toggle length; a short one stands in for a protected target
         lim <= fault_mode;
         abt <= abort_mode;
         ers <= 1'b0;
      end else if (flash_dq_out == 16'h0030 && susp) begin
         susp <= 1'b0; // Resume the suspended erase
      end else if (flash_dq_out == 16'h00b0) begin
         susp <= ers; // Suspend takes effect only once an erase has started; a program clears that
      end else if (flash_dq_out == 16'h0030) begin
         ers <= 1'b1;
         eto <= 1'b0;
         left <= op_len; // Protected sectors only shorten or empty the erase
         esec <= flash_addr[23:16];
      end
      arm <= flash_dq_out == 16'h00a0;
      w2 <= w1;
      w1 <= flash_dq_out;
   end
   // Status changes only once per fresh output enable
   always @(posedge flash_oe_n) begin
      if (left != 4'h0 || lim || abt) begin
         flash_dq_in <= {8'h00, ers ? susp : ~pd[7], t1, lim, 1'b0, eto, t2, abt, 1'b0};
         t1 <= susp ? t1 : ~t1;
         t2 <= sel ? ~t2 : t2;
         eto <= ers;
         if (left != 4'h0 && !lim && !abt && !susp) begin
            left <= left - 4'h1;
         end
      end else begin
         flash_dq_in <= 16'h00c3;
      end
   end
endmodule

/* File: verification/fwsr_host_test.sv */
/*
 Self-checking bench for the flash status polling host over APB.
 Assumes the flash model in fwsr_flash_model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module fwsr_host_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n, ready_busy_n;
   logic [23:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in;
   logic fault_mode = 1'b0, abort_mode = 1'b0;
   logic [3:0] op_len = 4'h5;
   int err_count = 0, n_compared = 0;
   fwsr_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
   fwsr_flash_model u_flash (.flash_addr(flash_addr), .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .fault_mode(fault_mode),
      .abort_mode(abort_mode), .op_len(op_len), .flash_dq_in(flash_dq_in),
      .ready_busy_n(ready_busy_n));
   // Clock at 40 MHz
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One APB transfer; result in q and e
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         end_of_test();
      end
   endtask
   // Start a command and wait for busy to clear
   task automatic run(input logic [2:0] c);
      int n;
      n = 0;
      apb(1'b1, fwsr_pkg::ADDR_CTRL, {28'h0, c, 1'b1});
      do begin
         apb(1'b0, fwsr_pkg::ADDR_STAT, 32'h0);
         n++;
      end while (q[fwsr_pkg::ST_BUSY] !== 1'b0 && n < 200);
      if (n >= 200) begin
         err_count++;
         end_of_test();
      end
   endtask
   task automatic fw(input logic [23:0] a, input logic [15:0] d);
      apb(1'b1, fwsr_pkg::ADDR_ADDR, {8'h00, a});
      apb(1'b1, fwsr_pkg::ADDR_DATA, {16'h0000, d});
      run(fwsr_pkg::CMD_WRITE);
   endtask
   task automatic unlock(input logic [15:0] c);
      fw(fwsr_pkg::WA_555, fwsr_pkg::WD_AA);
      fw(fwsr_pkg::WA_2AA, fwsr_pkg::WD_55);
      fw(fwsr_pkg::WA_555, c);
   endtask
   // Program a word, poll and check the flags, reset both ways, then read the array word 00c3 at that address
   task automatic t_prog(input logic f, input logic ab);
      fault_mode <= f;
      abort_mode <= ab;
      unlock(16'h00a0);
      fw(24'h000100, 16'h0042);
      run(fwsr_pkg::CMD_POLL);
      `CHK("done", !f && !ab, q[fwsr_pkg::ST_DONE])
      `CHK("fail", f, q[fwsr_pkg::ST_FAIL])
      `CHK("abort", ab, q[fwsr_pkg::ST_ABORT])
      run(fwsr_pkg::CMD_RESET);
      `CHK("ready after reset", !ab, q[fwsr_pkg::ST_RB])
      run(fwsr_pkg::CMD_ABORT_RESET);
      `CHK("ready", 1'b1, q[fwsr_pkg::ST_RB])
      fault_mode <= 1'b0;
      abort_mode <= 1'b0;
      run(fwsr_pkg::CMD_READ);
      apb(1'b0, fwsr_pkg::ADDR_RDAT, 32'h0);
      `CHK("array word", 16'h00c3, q[15:0])
   endtask
   // Sector erase: acceptance window closes, suspend and resume, then poll to the end
   task automatic t_erase;
      unlock(16'h0080);
      fw(24'h020000, 16'h0030);
      run(fwsr_pkg::CMD_ERASE_CHECK);
      `CHK("erase started", 1'b1, q[fwsr_pkg::ST_ERASE_STARTED])
      fw(24'h020000, 16'h00b0);
      run(fwsr_pkg::CMD_POLL);
      `CHK("suspended seen", 1'b1, q[fwsr_pkg::ST_SUSPENDED])
      `CHK("suspend steady", 1'b1, q[fwsr_pkg::ST_DONE])
      `CHK("ready in suspend", 1'b1, q[fwsr_pkg::ST_RB])
      fw(24'h020000, 16'h0030);
      run(fwsr_pkg::CMD_POLL);
      `CHK("erase done", 1'b1, q[fwsr_pkg::ST_DONE])
      `CHK("not suspended", 1'b0, q[fwsr_pkg::ST_SUSPENDED])
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, fwsr_pkg::ADDR_STAT, 32'h0);
      `CHK("idle ready", 2'b10, {q[fwsr_pkg::ST_RB], q[fwsr_pkg::ST_BUSY]})
      apb(1'b1, fwsr_pkg::ADDR_ADDR, 32'h00123456);
      apb(1'b0, fwsr_pkg::ADDR_ADDR, 32'h0);
      `CHK("addr reg", 24'h123456, q[23:0])
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", 1'b1, e)
      t_prog(1'b0, 1'b0);
      t_prog(1'b1, 1'b0);
      t_prog(1'b0, 1'b1);
      t_erase();
      end_of_test();
   end
endmodule
